// ==== rtl/hbag_host_addr_gen.sv ====
`timescale 1ns/1ns
// Behaviour
// R1 - Software writes the mode register first, then all transfer registers, then starts.
// R2 - Burst select high uses back-to-back burst accesses; low uses single accesses.
// R3 - Direction low reads DRAM toward the host bus; high writes host data in.
// R4 - Dual select low: single offset mode, one offset block per frame.
// R5 - Each frame runs start to end offset inclusive, then frame increments.
// R6 - Dual mode transfers range A then range B before the frame increments.
// R7 - After reset both start and end pair pointers select A.
// R8 - In dual mode a high byte write toggles that register's A/B pointer.
// R9 - Mode register read shows both pair pointer states as separate bits.
// R10 - Mode write with a pointer bit low clears that pointer to A.
// R11 - Frame counter loads from start frame, increments, clears after last frame.
// R12 - Software rewrites start frame to change the counter, every pass if non-zero.
// R13 - Current 9-bit frame readable as two read-only bytes, bit 8 upper.
// R14 - Start offset is 12 bits, low byte plus four-bit high byte.
// R15 - End offset is 12 bits, low byte plus four-bit high byte.
// R16 - Software writes A start offset last when both pairs are used.
// R17 - In dual mode reads after writing A return the B pair.
// R18 - Start frame acts on addressing at once, even mid-access.
// R19 - Nibble mode doubles burst time, single access 236 ns not 147.5 ns.
// R20 - Front-end writes come 833 ns apart; software avoids DRAM at frame end.
// R21 - Frame limit sets the wrap point of the frame counter.
// R22 - Each frame is 3 kbytes of DRAM.
// R23 - DRAM address is frame times frame size plus offset; offset steps per byte.
// R24 - A byte moves only when DMA request and buffer grant agree; else hold.
module hbag_host_addr_gen
  import hbag_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic dmaReq,
  input wire logic [7:0] dmaWrData,
  output logic dmaAck,
  output logic [7:0] dmaRdData,
  output hbag_dram_req_t bufReqOut,
  input wire logic bufGrant,
  input wire logic [7:0] bufRdData
);
  typedef struct packed {
    hbag_mode_t mode;
    logic [8:0] limit;
    logic [8:0] startFrame;
    logic [8:0] frame;
    logic [11:0] off;
    hbag_phase_t phase;
    logic [7:0] rdData;
    logic [7:0] wdata;
    logic [7:0] dmaRd;
  } hbag_main_t;

  hbag_main_t s_r;
  hbag_main_t s_nxt;

  logic wrMode;
  logic wrOffsLo;
  logic wrOffsHi;
  logic wrOffeLo;
  logic wrOffeHi;
  logic startPtr;
  logic endPtr;
  logic [11:0] startRd;
  logic [11:0] startA;
  logic [11:0] startB;
  logic [11:0] endRd;
  logic [11:0] endA;
  logic [11:0] endB;
  logic seqReq;
  logic move;
  logic [11:0] endSel;
  logic blockDone;
  logic frameDone;
  logic [9:0] frameInc;
  logic [8:0] frameNext;

  assign wrMode = regWr && (regAddr == HBAG_ADDR_MODE);
  assign wrOffsLo = regWr && (regAddr == HBAG_ADDR_OFFS_LO);
  assign wrOffsHi = regWr && (regAddr == HBAG_ADDR_OFFS_HI);
  assign wrOffeLo = regWr && (regAddr == HBAG_ADDR_OFFE_LO);
  assign wrOffeHi = regWr && (regAddr == HBAG_ADDR_OFFE_HI);

  hbag_offset_pair u_start_pair (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .wrLo(wrOffsLo),
    .wrHi(wrOffsHi),
    .wrData(regWrData),
    .dual(s_r.mode.dual),
    .ptrClr(wrMode && !regWrData[HBAG_MODE_STR_PTR]),
    .ptr(startPtr),
    .rdVal(startRd),
    .valA(startA),
    .valB(startB)
  );

  hbag_offset_pair u_end_pair (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .wrLo(wrOffeLo),
    .wrHi(wrOffeHi),
    .wrData(regWrData),
    .dual(s_r.mode.dual),
    .ptrClr(wrMode && !regWrData[HBAG_MODE_END_PTR]),
    .ptr(endPtr),
    .rdVal(endRd),
    .valA(endA),
    .valB(endB)
  );

  hbag_dram_seq u_seq (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .want(dmaReq),
    .burst(s_r.mode.burst),
    .nibble(s_r.mode.nibble),
    .grant(bufGrant),
    .req(seqReq),
    .move(move)
  );

  // Block and frame boundaries
  assign endSel = (s_r.phase == HBAG_PH_B) ? endB : endA;
  assign blockDone = move && (s_r.off == endSel); // R5
  assign frameDone = blockDone && (!s_r.mode.dual || s_r.phase == HBAG_PH_B); // R4 R6
  assign frameInc = {1'b0, s_r.frame} + 10'h001;
  // A limit of zero keeps the counter at frame zero
  assign frameNext = (frameInc >= {1'b0, s_r.limit}) ? HBAG_FRAME_RST : frameInc[8:0]; // R11 R21

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdData = 8'h00;
    if (dmaReq) s_nxt.wdata = dmaWrData;
    if (move && !s_r.mode.dirWrite) s_nxt.dmaRd = bufRdData; // R3

    // Offset and frame walk, frozen unless a byte really moves
    if (frameDone) begin
      s_nxt.phase = HBAG_PH_A;
      s_nxt.off = startA; // R5
      s_nxt.frame = frameNext; // R11
    end else if (blockDone) begin
      s_nxt.phase = HBAG_PH_B; // R6
      s_nxt.off = startB;
    end else if (move) begin
      s_nxt.off = s_r.off + 12'h001; // R23
    end

    if (regWr) begin
      unique case (regAddr)
        HBAG_ADDR_MODE: begin
          s_nxt.mode.burst = regWrData[HBAG_MODE_BURST];
          s_nxt.mode.dirWrite = regWrData[HBAG_MODE_DIR];
          s_nxt.mode.dual = regWrData[HBAG_MODE_DUAL];
          s_nxt.mode.nibble = regWrData[HBAG_MODE_NIBBLE];
        end
        HBAG_ADDR_OFFS_HI: begin
          // Writing the A start high byte reloads the running offset
          if (!startPtr) begin
            s_nxt.off = {regWrData[3:0], startA[7:0]}; // R16
            s_nxt.phase = HBAG_PH_A;
          end
        end
        HBAG_ADDR_SFRM_LO: begin
          s_nxt.startFrame[7:0] = regWrData;
        end
        HBAG_ADDR_SFRM_HI: begin
          s_nxt.startFrame[8] = regWrData[0];
          // Takes effect at once, even mid-access
          s_nxt.frame = {regWrData[0], s_r.startFrame[7:0]}; // R12 R18
        end
        HBAG_ADDR_LIMIT_LO: begin
          s_nxt.limit[7:0] = regWrData; // R21
        end
        HBAG_ADDR_LIMIT_HI: begin
          s_nxt.limit[8] = regWrData[0]; // R21
        end
        default: begin
        end
      endcase
    end

    if (regRd) begin
      unique case (regAddr)
        HBAG_ADDR_MODE: begin
          s_nxt.rdData[HBAG_MODE_BURST] = s_r.mode.burst;
          s_nxt.rdData[HBAG_MODE_DIR] = s_r.mode.dirWrite;
          s_nxt.rdData[HBAG_MODE_DUAL] = s_r.mode.dual;
          s_nxt.rdData[HBAG_MODE_STR_PTR] = startPtr; // R9
          s_nxt.rdData[HBAG_MODE_END_PTR] = endPtr; // R9
          s_nxt.rdData[HBAG_MODE_NIBBLE] = s_r.mode.nibble;
        end
        HBAG_ADDR_OFFS_LO: s_nxt.rdData = startRd[7:0]; // R14 R17
        HBAG_ADDR_OFFS_HI: s_nxt.rdData = {4'h0, startRd[11:8]}; // R14
        HBAG_ADDR_OFFE_LO: s_nxt.rdData = endRd[7:0]; // R15 R17
        HBAG_ADDR_OFFE_HI: s_nxt.rdData = {4'h0, endRd[11:8]}; // R15
        HBAG_ADDR_SFRM_LO: s_nxt.rdData = s_r.startFrame[7:0];
        HBAG_ADDR_SFRM_HI: s_nxt.rdData = {7'h00, s_r.startFrame[8]};
        HBAG_ADDR_CFRM_LO: s_nxt.rdData = s_r.frame[7:0]; // R13
        HBAG_ADDR_CFRM_HI: s_nxt.rdData = {7'h00, s_r.frame[8]}; // R13
        HBAG_ADDR_LIMIT_LO: s_nxt.rdData = s_r.limit[7:0];
        HBAG_ADDR_LIMIT_HI: s_nxt.rdData = {7'h00, s_r.limit[8]};
        default: s_nxt.rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_r <= '{
        mode: hbag_mode_t'(HBAG_MODE_RST),
        limit: HBAG_FRAME_RST,
        startFrame: HBAG_FRAME_RST,
        frame: HBAG_FRAME_RST,
        off: HBAG_OFF_RST,
        phase: HBAG_PH_A,
        rdData: 8'h00,
        wdata: 8'h00,
        dmaRd: 8'h00
      };
    end else begin
      s_r <= s_nxt;
    end
  end

  assign regRdData = s_r.rdData;
  assign dmaAck = move; // R24
  assign dmaRdData = s_r.dmaRd;
  // Address follows frame and offset registers with no extra stage
  assign bufReqOut.req = seqReq;
  assign bufReqOut.burst = s_r.mode.burst; // R2
  assign bufReqOut.write = s_r.mode.dirWrite; // R3
  assign bufReqOut.addr = 21'(s_r.frame) * HBAG_FRAME_BYTES + 21'(s_r.off); // R22 R23
  assign bufReqOut.wdata = s_r.wdata;

  // All checks below share the system clock and reset
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  sequence s_end_of_b;
    move && (s_r.phase == HBAG_PH_B) && (s_r.off == endB) && !regWr;
  endsequence

  sequence s_end_of_a;
    move && (s_r.phase == HBAG_PH_A) && (s_r.off == endA) && !regWr;
  endsequence

  sequence s_enter_b;
    (s_r.phase == HBAG_PH_B) && (s_r.off == $past(startB));
  endsequence

  a_offset_step: assert property (@(posedge clk_sys) disable iff (!rstn) // R23
    move && (s_r.off != endSel) && !regWr |=> s_r.off == $past(s_r.off) + 12'h001)
    else $error("offset did not advance by one after a byte");
  a_dual_a_to_b: assert property (@(posedge clk_sys) disable iff (!rstn) // R6
    s_end_of_a and s_r.mode.dual |=> s_enter_b and s_r.frame == $past(s_r.frame))
    else $error("dual mode did not switch to range B in the same frame");
  a_single_wrap: assert property (@(posedge clk_sys) disable iff (!rstn) // R4
    s_end_of_a and !s_r.mode.dual |=> s_r.phase == HBAG_PH_A && s_r.off == $past(startA)
      && s_r.frame == $past(frameNext))
    else $error("single mode did not restart the block in the next frame");
  a_frame_clear: assert property (@(posedge clk_sys) disable iff (!rstn) // R11
    frameDone && !regWr && (frameInc >= {1'b0, s_r.limit}) |=> s_r.frame == 9'h000)
    else $error("frame counter not cleared after the last frame");
  a_stall_hold: assert property (@(posedge clk_sys) disable iff (!rstn) // R24
    !move && !regWr |=> $stable(s_r.off) && $stable(s_r.frame) && $stable(s_r.phase))
    else $error("address state changed while stalled");
  a_read_path: assert property (@(posedge clk_sys) disable iff (!rstn) // R3
    move && !s_r.mode.dirWrite |=> dmaRdData == $past(bufRdData))
    else $error("buffer read data not passed to the host side");
  a_mode_ptrs: assert property (@(posedge clk_sys) disable iff (!rstn) // R9
    regRd && regAddr == HBAG_ADDR_MODE |=> regRdData[HBAG_MODE_STR_PTR] == $past(startPtr)
      && regRdData[HBAG_MODE_END_PTR] == $past(endPtr))
    else $error("mode read does not show the pair pointers");
  a_cfrm_high: assert property (@(posedge clk_sys) disable iff (!rstn) // R13
    regRd && regAddr == HBAG_ADDR_CFRM_HI |=> regRdData == {7'h00, $past(s_r.frame[8])})
    else $error("current frame high byte read wrong");
  a_sfrm_load: assert property (@(posedge clk_sys) disable iff (!rstn) // R18
    regWr && regAddr == HBAG_ADDR_SFRM_HI |=> s_r.frame == {$past(regWrData[0]),
      $past(s_r.startFrame[7:0])})
    else $error("start frame write did not load the frame counter");
  a_ptr_clear: assert property (@(posedge clk_sys) disable iff (!rstn) // R10
    wrMode && !regWrData[HBAG_MODE_STR_PTR] && !regWrData[HBAG_MODE_END_PTR]
      |=> !startPtr && !endPtr)
    else $error("mode write did not clear the pair pointers");

  // Walk of the offset and frame counters
  a_dual_b_to_next: assert property ( // R6
    s_end_of_b and s_r.mode.dual |=> s_r.phase == HBAG_PH_A && s_r.off == $past(startA))
    else $error("dual mode did not return to range A after range B");
  a_frame_step: assert property ( // R11
    frameDone && !regWr && (frameInc < {1'b0, s_r.limit})
      |=> s_r.frame == $past(s_r.frame) + 9'h001)
    else $error("frame counter did not step after a frame");
  a_addr_step: assert property ( // R23
    move && !blockDone && !regWr |=> bufReqOut.addr == $past(bufReqOut.addr) + 21'h0_0001)
    else $error("buffer address did not advance by one byte");
  a_addr_stall: assert property ( // R24
    seqReq && !bufGrant && !regWr |=> $stable(bufReqOut.addr))
    else $error("buffer address moved during a stalled request");
  a_frame_stride: assert property ( // R22
    regWr && regAddr == HBAG_ADDR_SFRM_HI && !regWrData[0] && !move
      && s_r.startFrame[7:0] == 8'h01
      |=> bufReqOut.addr == HBAG_FRAME_BYTES + 21'($past(s_r.off)))
    else $error("frame one does not start one frame size up");
  a_start_reload: assert property ( // R16
    wrOffsHi && !startPtr |=> s_r.phase == HBAG_PH_A
      && s_r.off == {$past(regWrData[3:0]), $past(startA[7:0])})
    else $error("writing the A start offset did not reload the counter");

  // Mode bits and access pacing
  a_burst_flag: assert property ( // R2
    wrMode |=> bufReqOut.burst == $past(regWrData[HBAG_MODE_BURST]))
    else $error("burst select not taken from the mode write");
  a_dir_flag: assert property ( // R3
    wrMode |=> bufReqOut.write == $past(regWrData[HBAG_MODE_DIR]))
    else $error("direction not taken from the mode write");
  a_burst_stream: assert property ( // R2
    move && s_r.mode.burst && !s_r.mode.nibble |=> seqReq == dmaReq)
    else $error("byte burst did not keep the request up");
  a_nib_burst_gap: assert property ( // R19
    move && s_r.mode.burst && s_r.mode.nibble |=> !seqReq ##1 seqReq == dmaReq)
    else $error("nibble burst not spaced by one idle cycle");

  // Register reads and frame limit load
  a_cfrm_low: assert property ( // R13
    regRd && regAddr == HBAG_ADDR_CFRM_LO |=> regRdData == $past(s_r.frame[7:0]))
    else $error("current frame low byte read wrong");
  a_offs_b_read: assert property ( // R17
    regRd && regAddr == HBAG_ADDR_OFFS_LO && startPtr |=> regRdData == $past(startB[7:0]))
    else $error("start offset read did not reach the B register");
  a_offe_a_read: assert property ( // R15
    regRd && regAddr == HBAG_ADDR_OFFE_HI && !endPtr
      |=> regRdData == {4'h0, $past(endA[11:8])})
    else $error("end offset high byte read wrong");
  a_offs_hi_read: assert property ( // R14
    regRd && regAddr == HBAG_ADDR_OFFS_HI |=> regRdData[7:4] == 4'h0)
    else $error("start offset high byte shows bits above the offset");
  a_limit_load: assert property ( // R21
    regWr && regAddr == HBAG_ADDR_LIMIT_HI
      |=> s_r.limit == {$past(regWrData[0]), $past(s_r.limit[7:0])})
    else $error("frame limit high byte not stored");
endmodule

// ==== rtl/hbag_pkg.sv ====
package hbag_pkg;

  // Byte-wide register addresses on the microcontroller register port
  localparam logic [15:0] HBAG_ADDR_MODE = 16'hF0E1;
  localparam logic [15:0] HBAG_ADDR_OFFS_LO = 16'hF0E8;
  localparam logic [15:0] HBAG_ADDR_OFFS_HI = 16'hF0E9;
  localparam logic [15:0] HBAG_ADDR_OFFE_LO = 16'hF0EA;
  localparam logic [15:0] HBAG_ADDR_OFFE_HI = 16'hF0EB;
  localparam logic [15:0] HBAG_ADDR_SFRM_LO = 16'hF0EC;
  localparam logic [15:0] HBAG_ADDR_SFRM_HI = 16'hF0ED;
  localparam logic [15:0] HBAG_ADDR_CFRM_LO = 16'hF0EE;
  localparam logic [15:0] HBAG_ADDR_CFRM_HI = 16'hF0EF;
  localparam logic [15:0] HBAG_ADDR_LIMIT_LO = 16'hF0F8;
  localparam logic [15:0] HBAG_ADDR_LIMIT_HI = 16'hF0F9;

  // Mode register bit positions
  localparam int HBAG_MODE_BURST = 0;
  localparam int HBAG_MODE_DIR = 1;
  localparam int HBAG_MODE_DUAL = 2;
  localparam int HBAG_MODE_STR_PTR = 3;
  localparam int HBAG_MODE_END_PTR = 4;
  localparam int HBAG_MODE_NIBBLE = 5;

  // Values after reset
  localparam logic [3:0] HBAG_MODE_RST = 4'h0;
  localparam logic [8:0] HBAG_FRAME_RST = 9'h000;
  localparam logic [11:0] HBAG_OFF_RST = 12'h000;
  localparam logic [2:0] HBAG_PACE_RST = 3'h0;

  // One frame is 3 kbytes of DRAM
  localparam logic [20:0] HBAG_FRAME_BYTES = 21'h0_0C00;

  // Access pacing at the 50 ns system clock
  localparam int HBAG_CLK_PS = 50000;
  localparam int HBAG_T_SINGLE_BYTE_PS = 147500;
  localparam int HBAG_T_SINGLE_NIB_PS = 236000;
  localparam int HBAG_CYC_SINGLE_BYTE = (HBAG_T_SINGLE_BYTE_PS + HBAG_CLK_PS - 1) / HBAG_CLK_PS;
  localparam int HBAG_CYC_SINGLE_NIB = (HBAG_T_SINGLE_NIB_PS + HBAG_CLK_PS - 1) / HBAG_CLK_PS;
  localparam int HBAG_CYC_BURST_BYTE = 1;
  localparam int HBAG_CYC_BURST_NIB = 2 * HBAG_CYC_BURST_BYTE;

  typedef struct packed {
    logic nibble;
    logic dual;
    logic dirWrite;
    logic burst;
  } hbag_mode_t;

  typedef struct packed {
    logic req;
    logic burst;
    logic write;
    logic [20:0] addr;
    logic [7:0] wdata;
  } hbag_dram_req_t;

  typedef struct packed {
    logic ptr;
    logic [11:0] a;
    logic [11:0] b;
  } hbag_pair_t;

  typedef struct packed {
    logic [2:0] pace;
  } hbag_seq_t;

  typedef enum logic [0:0] {
    HBAG_PH_A = 1'b0,
    HBAG_PH_B = 1'b1
  } hbag_phase_t;

endpackage

// ==== rtl/hbag_offset_pair.sv ====
`timescale 1ns/1ns
module hbag_offset_pair
  import hbag_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic wrLo,
  input wire logic wrHi,
  input wire logic [7:0] wrData,
  input wire logic dual,
  input wire logic ptrClr,
  output logic ptr,
  output logic [11:0] rdVal,
  output logic [11:0] valA,
  output logic [11:0] valB
);
  hbag_pair_t s_r;
  hbag_pair_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (wrLo) begin
      if (s_r.ptr) s_nxt.b[7:0] = wrData;
      else s_nxt.a[7:0] = wrData;
    end
    if (wrHi) begin
      if (s_r.ptr) s_nxt.b[11:8] = wrData[3:0];
      else s_nxt.a[11:8] = wrData[3:0];
      if (dual) s_nxt.ptr = ~s_r.ptr; // R8
    end
    if (ptrClr) s_nxt.ptr = 1'b0; // R10
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_r <= '{ptr: 1'b0, a: HBAG_OFF_RST, b: HBAG_OFF_RST}; // R7
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ptr = s_r.ptr;
  assign rdVal = s_r.ptr ? s_r.b : s_r.a; // R17
  assign valA = s_r.a;
  assign valB = s_r.b;

  a_ptr_toggle_hi: assert property (@(posedge clk_sys) disable iff (!rstn) // R8
    wrHi && dual && !ptrClr |=> ptr != $past(ptr))
    else $error("pair pointer did not toggle on high byte write");
  a_ptr_single_hold: assert property (@(posedge clk_sys) disable iff (!rstn) // R4
    !dual && !ptrClr |=> ptr == $past(ptr))
    else $error("pair pointer moved in single offset mode");
endmodule

// ==== rtl/hbag_dram_seq.sv ====
`timescale 1ns/1ns
module hbag_dram_seq
  import hbag_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic want,
  input wire logic burst,
  input wire logic nibble,
  input wire logic grant,
  output logic req,
  output logic move
);
  hbag_seq_t s_r;
  hbag_seq_t s_nxt;
  logic [2:0] gap;

  // Single accesses and nibble bursts drop the request between bytes, byte bursts hold it
  always_comb begin
    unique case ({burst, nibble})
      2'b00: gap = 3'(HBAG_CYC_SINGLE_BYTE - 1); // R2
      2'b01: gap = 3'(HBAG_CYC_SINGLE_NIB - 1); // R19
      2'b10: gap = 3'(HBAG_CYC_BURST_BYTE - 1); // R2
      2'b11: gap = 3'(HBAG_CYC_BURST_NIB - 1); // R19
    endcase
  end

  assign req = want && (s_r.pace == 3'h0);
  assign move = req && grant; // R24

  always_comb begin
    s_nxt = s_r;
    if (move) s_nxt.pace = gap;
    else if (s_r.pace != 3'h0) s_nxt.pace = s_r.pace - 3'h1;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) s_r <= '{pace: HBAG_PACE_RST};
    else s_r <= s_nxt;
  end

  a_single_byte_gap: assert property (@(posedge clk_sys) disable iff (!rstn) // R2
    move && !burst && !nibble |=> !req [*2])
    else $error("single byte access spaced too closely");
  a_nibble_gap: assert property (@(posedge clk_sys) disable iff (!rstn) // R19
    move && !burst && nibble |=> !req [*4])
    else $error("nibble single access spaced too closely");
endmodule

// ==== test/hbag_dram_model.sv ====
`timescale 1ns/1ns
module hbag_dram_model
  import hbag_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input hbag_dram_req_t bufReqOut,
  input wire logic [3:0] stall,
  output logic bufGrant,
  output logic [7:0] bufRdData
);
  logic [7:0] mem [int];
  logic [3:0] waitCnt = 4'h0;
  logic pend = 1'b0;
  logic [20:0] pendAddr = 21'h0_0000;

  function automatic logic [7:0] rd(input logic [20:0] a);
    return mem.exists(a) ? mem[a] : a[7:0] ^ a[15:8];
  endfunction

  initial begin
    bufGrant = 1'b0;
    bufRdData = 8'h00;
  end

  // Arbiter answers after the far edge; data line churns when not granted
  always @(negedge clk_sys) begin
    #1;
    if (bufReqOut.req && rstn && waitCnt >= stall) begin
      bufGrant = 1'b1;
      bufRdData = rd(bufReqOut.addr);
      waitCnt = 4'h0;
    end else begin
      bufGrant = 1'b0;
      bufRdData = ~bufRdData;
      if (bufReqOut.req) begin
        waitCnt = waitCnt + 4'h1;
      end
    end
  end

  // Write data trails the move by one cycle, so commit on the next edge
  always @(posedge clk_sys) begin
    if (pend) begin
      mem[pendAddr] = bufReqOut.wdata;
    end
    pend = bufReqOut.req && bufGrant && bufReqOut.write && rstn;
    pendAddr = bufReqOut.addr;
  end
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ns
module tb_top
  import hbag_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdData;
  logic dmaReq = 1'b0;
  logic [7:0] dmaWrData = 8'h00;
  logic dmaAck;
  logic [7:0] dmaRdData;
  hbag_dram_req_t bufReqOut;
  logic bufGrant;
  logic [7:0] bufRdData;
  logic [3:0] stall = 4'h0;
  int errors = 0;
  int checks = 0;
  int sA, eA, sB, eB, lim, frm, off, ph, dual;
  logic wm, bm;
  logic [7:0] v;

  hbag_host_addr_gen uut (.clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .dmaReq(dmaReq), .dmaWrData(dmaWrData), .dmaAck(dmaAck), .dmaRdData(dmaRdData),
    .bufReqOut(bufReqOut), .bufGrant(bufGrant), .bufRdData(bufRdData));

  hbag_dram_model u_mem (.clk_sys(clk_sys), .rstn(rstn), .bufReqOut(bufReqOut),
    .stall(stall), .bufGrant(bufGrant), .bufRdData(bufRdData));

  always #25 clk_sys = ~clk_sys;

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    regAddr = a;
    regWrData = d;
    regWr = 1'b1;
    @(negedge clk_sys);
    regWr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    regAddr = a;
    regRd = 1'b1;
    @(negedge clk_sys);
    regRd = 1'b0;
    d = regRdData;
  endtask

  // Low byte first, the high byte commits the value
  task automatic wr2(input logic [15:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(a + 16'h0001, d[15:8]);
  endtask

  task automatic prog(input logic [7:0] m, input int sa, ea, sb, eb, sf, lm);
    wr(HBAG_ADDR_MODE, m);
    wr2(HBAG_ADDR_LIMIT_LO, lm[15:0]);
    wr2(HBAG_ADDR_OFFE_LO, ea[15:0]);
    if (m[HBAG_MODE_DUAL]) begin
      wr2(HBAG_ADDR_OFFE_LO, eb[15:0]);
      wr2(HBAG_ADDR_OFFS_LO, sa[15:0]);
      wr2(HBAG_ADDR_OFFS_LO, sb[15:0]);
    end
    wr2(HBAG_ADDR_SFRM_LO, sf[15:0]);
    wr2(HBAG_ADDR_OFFS_LO, sa[15:0]);
    {sA, eA, sB, eB, frm, lim, off, ph} = {sa, ea, sb, eb, sf, lm, sa, 32'd0};
    dual = m[HBAG_MODE_DUAL];
    wm = m[HBAG_MODE_DIR];
    bm = m[HBAG_MODE_BURST];
  endtask

  task automatic adv();
    if (off != (ph ? eB : eA)) begin
      off++;
    end else if (dual && !ph) begin
      ph = 1;
      off = sB;
    end else begin
      ph = 0;
      off = sA;
      frm = (frm + 1 >= lim) ? 0 : frm + 1;
    end
  endtask

  task automatic xfer(input int n, input int gap);
    int c;
    logic [20:0] a;
    logic [20:0] aq[$];
    logic [7:0] dq[$];
    @(negedge clk_sys);
    dmaWrData = 8'h3C;
    dmaReq = 1'b1;
    for (int i = 0; i < n; i++) begin
      c = 0;
      #20;
      while (dmaAck !== 1'b1 && c < 40) begin
        @(negedge clk_sys);
        #20;
        c++;
      end
      if (c >= 40) begin
        errors++;
        $display("ERROR %0t: no acknowledge", $time);
        dmaReq = 1'b0;
        return;
      end
      a = bufReqOut.addr;
      check(a, 21'(frm) * HBAG_FRAME_BYTES + 21'(off));
      check(bufReqOut.write, wm);
      check(bufReqOut.burst, bm);
      if (i > 0 && gap > 0) check(c + 1, gap);
      if (wm) begin
        aq.push_back(a);
        dq.push_back(dmaWrData);
      end
      adv();
      @(negedge clk_sys);
      if (!wm) check(dmaRdData, u_mem.rd(a));
      dmaWrData = dmaWrData + 8'h11;
    end
    dmaReq = 1'b0;
    repeat (2) @(negedge clk_sys);
    foreach (aq[k]) check(u_mem.mem[aq[k]], dq[k]);
  endtask

  task automatic t_reset();
    rd(HBAG_ADDR_MODE, v);
    check(v, 8'h00);
    wr(HBAG_ADDR_CFRM_LO, 8'h55);
    rd(HBAG_ADDR_CFRM_LO, v);
    check(v, 8'h00);
    @(negedge clk_sys);
    check(regRdData, 8'h00);
    rd(16'hF0E0, v);
    check(v, 8'h00);
  endtask

  task automatic t_pairs();
    wr(HBAG_ADDR_MODE, 8'h04);
    wr2(HBAG_ADDR_OFFS_LO, 16'hF234);
    rd(HBAG_ADDR_MODE, v);
    check(v, 8'h0C);
    rd(HBAG_ADDR_OFFS_LO, v);
    check(v, 8'h00);
    wr2(HBAG_ADDR_OFFE_LO, 16'h0ABC);
    rd(HBAG_ADDR_MODE, v);
    check(v, 8'h1C);
    wr(HBAG_ADDR_MODE, 8'h14);
    rd(HBAG_ADDR_MODE, v);
    check(v, 8'h14);
    rd(HBAG_ADDR_OFFS_HI, v);
    check(v, 8'h02);
    rd(HBAG_ADDR_OFFS_LO, v);
    check(v, 8'h34);
    wr(HBAG_ADDR_MODE, 8'h04);
    rd(HBAG_ADDR_OFFE_HI, v);
    check(v, 8'h0A);
    wr(HBAG_ADDR_MODE, 8'h00);
    wr2(HBAG_ADDR_OFFS_LO, 16'h0111);
    rd(HBAG_ADDR_MODE, v);
    check(v, 8'h00);
  endtask

  // Reset after both pair pointers toggle to B sends them back to A
  task automatic t_rerst();
    wr(HBAG_ADDR_MODE, 8'h04);
    wr2(HBAG_ADDR_OFFS_LO, 16'h0001);
    wr2(HBAG_ADDR_OFFE_LO, 16'h0002);
    rd(HBAG_ADDR_MODE, v);
    check(v, 8'h1C);
    rstn = 1'b0;
    repeat (2) @(negedge clk_sys);
    rstn = 1'b1;
    rd(HBAG_ADDR_MODE, v);
    check(v, 8'h00);
  endtask

  // Single offset, reads, frame wrap, every pacing mode
  task automatic t_modes();
    int gaps[4] = '{3, 5, 1, 2};
    for (int k = 0; k < 4; k++) begin
      prog({2'b00, k[0], 4'h0, k[1]}, 16, 18, 0, 0, 1, 2);
      xfer(7, gaps[k]);
      rd(HBAG_ADDR_CFRM_LO, v);
      check(v, frm[7:0]);
    end
  endtask

  // Dual offset burst writes with a slow arbiter
  task automatic t_dual();
    stall = 4'h2;
    prog(8'h07, 256, 257, 3070, 3071, 257, 259);
    xfer(4, 0);
    rd(HBAG_ADDR_CFRM_HI, v);
    check(v, 8'h01);
    xfer(5, 0);
    rd(HBAG_ADDR_CFRM_LO, v);
    check(v, 8'h00);
    wr2(HBAG_ADDR_SFRM_LO, 16'h0005);
    frm = 5;
    check(bufReqOut.addr, 21'(frm) * HBAG_FRAME_BYTES + 21'(off));
    stall = 4'h0;
  endtask

  initial begin
    repeat (10) @(negedge clk_sys);
    rstn = 1'b1;
    t_reset();
    t_pairs();
    t_rerst();
    t_modes();
    t_dual();
    end_of_test();
  end
endmodule
